// ==== mdce_cfg.svh ====
// Constants of the five-channel DMA channel engine
`ifndef MDCE_CFG_SVH
`define MDCE_CFG_SVH
`define MDCE_NCH 5
`define MDCE_OFS_PTR0 5'h00
`define MDCE_OFS_PTR1 5'h04
`define MDCE_OFS_ARM 5'h08
`define MDCE_OFS_SWREQ 5'h0c
`define MDCE_OFS_FLAG 5'h10
`define MDCE_OFS_STAT 5'h14
`define MDCE_OFS_CNT 5'h18
`define MDCE_ABORT_POS 7
`define MDCE_RST_PTR 16'h0000
`define MDCE_RST_FLAG 5'h00
`define MDCE_CFG_LAST 3'h7
`define MDCE_FETCH_CLKS 9
`define MDCE_TRIG_NONE 5'h00
`define MDCE_TRIG_PREV 5'h01
`define MDCE_M8_7BIT 1'b1
`endif

// ==== mdce_pkg.sv ====
// Types of the five-channel DMA channel engine
package mdce_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_FETCH = 3'b001, ST_FDONE = 3'b010, ST_RD = 3'b011, ST_WR = 3'b100
  } mdce_phase_t;
  typedef enum logic [1:0] {
    PRIO_LOW = 2'b00, PRIO_NORM = 2'b01, PRIO_HIGH = 2'b10
  } mdce_prio_t;
  typedef enum logic [1:0] {
    TM_SINGLE = 2'b00, TM_BLOCK = 2'b01, TM_RSINGLE = 2'b10, TM_RBLOCK = 2'b11
  } mdce_tmode_t;
  typedef enum logic [1:0] {
    INC_0 = 2'b00, INC_1 = 2'b01, INC_2 = 2'b10, DEC_1 = 2'b11
  } mdce_inc_t;
  typedef enum logic [2:0] {
    VL_FIXED = 3'b000, VL_P1 = 3'b001, VL_N = 3'b010, VL_P2 = 3'b011, VL_P3 = 3'b100
  } mdce_variable_length_mode_t;
  // Eight-byte record, byte 0 in the top bits
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [2:0] variable_length_mode;
    logic [12:0] len;
    logic word;
    logic [1:0] tmode;
    logic [4:0] trig;
    logic [1:0] sinc;
    logic [1:0] dinc;
    logic irqm;
    logic m8;
    logic [1:0] prio;
  } mdce_cfg_t;
  typedef struct packed {
    mdce_cfg_t cfg;
    logic [15:0] wsrc;
    logic [15:0] wdst;
    logic [12:0] cnt;
    logic [12:0] tot;
    logic armed;
    logic pend;
    logic run;
  } mdce_chan_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mdce_mem_t;
  typedef struct packed {
    mdce_chan_t [4:0] chans;
    mdce_phase_t phase;
    logic [2:0] ch;
    logic [2:0] bidx;
    logic cap;
    logic [15:0] data;
    logic [4:0] fetch_q;
    logic [2:0] rr;
    logic alt;
    logic [4:0] flags;
    logic [4:0] irq;
    logic [4:0] done;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [2:0] csel;
    logic ack;
    logic [31:0] rdata;
  } mdce_state_t;
endpackage : mdce_pkg

// ==== mdce_engine.sv ====
// Five-channel DMA engine with Avalon-MM register slave and memory port
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "mdce_cfg.svh"
module mdce_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Shared memory port
  output mdce_pkg::mdce_mem_t mem,
  input wire logic [7:0] mem_rdata,
  input wire logic cpu_req,
  output logic cpu_gnt,
  // Triggers and completion requests
  input wire logic [31:0] trig_in,
  output logic [4:0] irq_req
);
  import mdce_pkg::*;

  mdce_state_t s_q;
  mdce_state_t s_d;
  mdce_chan_t cur;
  mdce_cfg_t full;
  mdce_mem_t mreq;
  logic want;
  logic win;
  logic gnt;
  logic last;
  logic wr_en;
  logic hit;
  logic is_var;
  logic [1:0] prio;
  logic [3:0] sel;
  logic [4:0] abort_m;
  logic [9:0] prios;
  logic [12:0] cnt_n;
  logic [12:0] tot;
  logic [12:0] n;
  logic [13:0] vt;
  logic [3:0] fnext;

  // Step a working pointer after one unit
  function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] inc);
    logic [15:0] r;
    case (inc)
      INC_0: r = a;
      INC_1: r = a + 16'h0001;
      INC_2: r = a + 16'h0002;
      DEC_1: r = a - 16'h0001;
      default: r = a;
    endcase
    return r;
  endfunction : step_addr

  // Total units for a variable-length option
  function automatic logic [13:0] variable_length_mode_total(input logic [2:0] v, input logic [12:0] len);
    logic [13:0] r;
    case (v)
      VL_P1: r = {1'b0, len} + 14'h0001;
      VL_N: r = {1'b0, len};
      VL_P2: r = {1'b0, len} + 14'h0002;
      VL_P3: r = {1'b0, len} + 14'h0003;
      default: r = 14'h0000;
    endcase
    return r;
  endfunction : variable_length_mode_total

  // Highest level first, then round robin after the last winner
  function automatic logic [3:0] pick_chan(input logic [4:0] cand, input logic [9:0] pr,
                                           input logic [2:0] rr);
    logic [3:0] r;
    logic [2:0] idx;
    logic [1:0] p;
    logic [1:0] lv;
    r = 4'h0;
    for (int l = 2; l >= 0; l--) begin
      for (int k = 1; k <= 5; k++) begin
        idx = 3'((int'(rr) + k) % 5);
        p = pr[idx*2 +: 2];
        lv = (p >= PRIO_HIGH) ? 2'h2 : p;
        if (!r[3] && cand[idx] && lv == 2'(l)) begin
          r = {1'b1, idx};
        end
      end
    end
    return r;
  endfunction : pick_chan

  // Next record to fetch: channels 1 to 4 in order, channel 0 last
  function automatic logic [3:0] next_fetch(input logic [4:0] q);
    logic [3:0] r;
    r = {|q, 3'h0};
    for (int i = 4; i >= 1; i--) begin
      if (q[i]) begin
        r[2:0] = 3'(i);
      end
    end
    return r;
  endfunction : next_fetch

  always_comb begin
    s_d = s_q;
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    s_d.irq = 5'h00;
    s_d.done = 5'h00;
    wr_en = avs_write & s_q.ack;
    cur = s_q.chans[s_q.ch];
    full = mdce_cfg_t'({cur.cfg[55:0], mem_rdata});
    mreq = '0;
    want = 1'b0;
    last = 1'b0;
    cnt_n = 13'h0000;
    tot = 13'h0000;
    n = 13'h0000;
    vt = 14'h0000;
    is_var = 1'b0;
    hit = 1'b0;
    sel = 4'h0;
    fnext = 4'h0;
    abort_m = 5'h00;
    prios = 10'h000;

    // Memory request of the current phase
    case (s_q.phase)
      ST_FETCH: begin
        want = 1'b1;
        mreq.addr = (s_q.ch == 3'h0) ? s_q.ptr0 + {13'h0000, s_q.bidx}
                  : s_q.ptr1 + {10'h000, 3'(s_q.ch - 3'h1), s_q.bidx};
      end
      ST_RD: begin
        want = 1'b1;
        mreq.addr = cur.wsrc + {15'h0000, s_q.bidx[0]};
        last = ~cur.cfg.word | s_q.bidx[0];
      end
      ST_WR: begin
        // Wait for the last read byte before writing it
        want = ~s_q.cap;
        mreq.we = 1'b1;
        mreq.addr = cur.wdst + {15'h0000, s_q.bidx[0]};
        mreq.wdata = (cur.cfg.word & ~s_q.bidx[0]) ? s_q.data[15:8] : s_q.data[7:0];
        last = ~cur.cfg.word | s_q.bidx[0];
      end
      default: ;
    endcase

    // Contest against the processor; fetches always win
    prio = (s_q.phase == ST_FETCH) ? PRIO_HIGH : cur.cfg.prio;
    win = ~cpu_req | (prio >= PRIO_HIGH) | ((prio == PRIO_NORM) & s_q.alt);
    if (want & cpu_req & (prio == PRIO_NORM)) begin
      s_d.alt = ~s_q.alt;
    end
    gnt = want & win;
    mreq.req = gnt;
    s_d.cap = gnt & ~mreq.we;

    // Read data arrives the cycle after a granted read
    if (s_q.cap) begin
      if (s_q.phase == ST_FETCH || s_q.phase == ST_FDONE) begin
        s_d.chans[s_q.ch].cfg = full;
      end else begin
        s_d.data = {s_q.data[7:0], mem_rdata};
      end
    end

    case (s_q.phase)
      ST_IDLE: begin
        fnext = next_fetch(s_q.fetch_q);
        if (fnext[3]) begin
          s_d.ch = fnext[2:0];
          s_d.fetch_q[fnext[2:0]] = 1'b0;
          s_d.chans[fnext[2:0]].armed = 1'b0;
          s_d.bidx = 3'h0;
          s_d.phase = ST_FETCH;
        end else begin
          for (int i = 0; i < `MDCE_NCH; i++) begin
            prios[i*2 +: 2] = s_q.chans[i].cfg.prio;
          end
          sel = pick_chan({s_q.chans[4].armed & (s_q.chans[4].pend | s_q.chans[4].run),
                           s_q.chans[3].armed & (s_q.chans[3].pend | s_q.chans[3].run),
                           s_q.chans[2].armed & (s_q.chans[2].pend | s_q.chans[2].run),
                           s_q.chans[1].armed & (s_q.chans[1].pend | s_q.chans[1].run),
                           s_q.chans[0].armed & (s_q.chans[0].pend | s_q.chans[0].run)},
                          prios, s_q.rr);
          if (sel[3]) begin
            s_d.ch = sel[2:0];
            s_d.rr = sel[2:0];
            s_d.chans[sel[2:0]].pend = 1'b0;
            s_d.chans[sel[2:0]].run = 1'b1;
            s_d.bidx = 3'h0;
            s_d.phase = ST_RD;
          end
        end
      end
      ST_FETCH: begin
        if (gnt) begin
          s_d.bidx = s_q.bidx + 3'h1;
          if (s_q.bidx == `MDCE_CFG_LAST) begin
            s_d.phase = ST_FDONE;
          end
        end
      end
      ST_FDONE: begin
        // Last record byte lands now; channel ready at the ninth edge
        s_d.chans[s_q.ch].cfg = full;
        s_d.chans[s_q.ch].wsrc = full.src;
        s_d.chans[s_q.ch].wdst = full.dst;
        s_d.chans[s_q.ch].cnt = 13'h0000;
        s_d.chans[s_q.ch].tot = full.len;
        s_d.chans[s_q.ch].pend = 1'b0;
        s_d.chans[s_q.ch].run = 1'b0;
        s_d.chans[s_q.ch].armed = 1'b1;
        s_d.phase = ST_IDLE;
        fnext = next_fetch(s_q.fetch_q);
        if (fnext[3]) begin
          // Chained with no idle cycle, so five records take 45 clocks
          s_d.ch = fnext[2:0];
          s_d.fetch_q[fnext[2:0]] = 1'b0;
          s_d.chans[fnext[2:0]].armed = 1'b0;
          s_d.bidx = 3'h0;
          s_d.phase = ST_FETCH;
        end
      end
      ST_RD: begin
        if (gnt) begin
          s_d.bidx = last ? 3'h0 : s_q.bidx + 3'h1;
          if (last) begin
            s_d.phase = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (gnt && !last) begin
          s_d.bidx = s_q.bidx + 3'h1;
        end else if (gnt) begin
          s_d.phase = ST_IDLE;
          s_d.bidx = 3'h0;
          s_d.chans[s_q.ch].wsrc = step_addr(cur.wsrc, cur.cfg.sinc);
          s_d.chans[s_q.ch].wdst = step_addr(cur.wdst, cur.cfg.dinc);
          cnt_n = cur.cnt + 13'h0001;
          tot = cur.tot;
          is_var = (cur.cfg.variable_length_mode != VL_FIXED) && (cur.cfg.variable_length_mode <= VL_P3);
          if (cur.cnt == 13'h0000 && is_var) begin
            // Length width select only matters for byte units
            if (cur.cfg.word) begin
              n = s_q.data[12:0];
            end else if (cur.cfg.m8 == `MDCE_M8_7BIT) begin
              n = {6'h00, s_q.data[6:0]};
            end else begin
              n = {5'h00, s_q.data[7:0]};
            end
            vt = variable_length_mode_total(cur.cfg.variable_length_mode, n);
            if (vt < {1'b0, cur.cfg.len}) begin
              tot = vt[12:0];
            end
          end
          s_d.chans[s_q.ch].cnt = cnt_n;
          s_d.chans[s_q.ch].tot = tot;
          if (cur.cfg.tmode == TM_SINGLE || cur.cfg.tmode == TM_RSINGLE) begin
            s_d.chans[s_q.ch].run = 1'b0;
          end
          if (cnt_n >= tot) begin
            s_d.done[s_q.ch] = 1'b1;
            s_d.irq[s_q.ch] = cur.cfg.irqm;
            s_d.chans[s_q.ch].run = 1'b0;
            s_d.chans[s_q.ch].pend = 1'b0;
            if (cur.cfg.tmode == TM_RSINGLE || cur.cfg.tmode == TM_RBLOCK) begin
              s_d.chans[s_q.ch].wsrc = cur.cfg.src;
              s_d.chans[s_q.ch].wdst = cur.cfg.dst;
              s_d.chans[s_q.ch].cnt = 13'h0000;
              s_d.chans[s_q.ch].tot = cur.cfg.len;
            end else begin
              s_d.chans[s_q.ch].armed = 1'b0;
            end
          end
        end
      end
      default: s_d.phase = ST_IDLE;
    endcase

    // Triggers latch only on armed channels; set wins over the start clear
    for (int i = 0; i < `MDCE_NCH; i++) begin
      case (s_q.chans[i].cfg.trig)
        `MDCE_TRIG_NONE: hit = 1'b0;
        `MDCE_TRIG_PREV: hit = s_q.done[(i + 4) % 5];
        default: hit = trig_in[s_q.chans[i].cfg.trig];
      endcase
      if (wr_en && avs_address == `MDCE_OFS_SWREQ && avs_byteenable[0]) begin
        hit = hit | avs_writedata[i];
      end
      if (hit && s_d.chans[i].armed) begin
        s_d.chans[i].pend = 1'b1;
      end
    end

    // Completion flags: write one to clear, a new completion wins
    if (wr_en && avs_address == `MDCE_OFS_FLAG && avs_byteenable[0]) begin
      s_d.flags = s_q.flags & ~avs_writedata[4:0];
    end
    s_d.flags = s_d.flags | s_d.done;

    // Register writes
    if (wr_en) begin
      case (avs_address)
        `MDCE_OFS_PTR0: begin
          if (avs_byteenable[0]) s_d.ptr0[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) s_d.ptr0[15:8] = avs_writedata[15:8];
        end
        `MDCE_OFS_PTR1: begin
          if (avs_byteenable[0]) s_d.ptr1[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) s_d.ptr1[15:8] = avs_writedata[15:8];
        end
        `MDCE_OFS_ARM: begin
          if (avs_byteenable[0] && avs_writedata[`MDCE_ABORT_POS]) begin
            abort_m = avs_writedata[4:0];
          end else if (avs_byteenable[0]) begin
            s_d.fetch_q = s_d.fetch_q | avs_writedata[4:0];
          end
        end
        `MDCE_OFS_CNT: begin
          if (avs_byteenable[0] && avs_writedata[2:0] < 3'h5) s_d.csel = avs_writedata[2:0];
        end
        default: ;
      endcase
    end

    // Abort wins over arming, triggers and a running fetch or transfer for the chosen channels
    for (int i = 0; i < `MDCE_NCH; i++) begin
      if (abort_m[i]) begin
        s_d.chans[i].armed = 1'b0;
        s_d.chans[i].pend = 1'b0;
        s_d.chans[i].run = 1'b0;
        s_d.fetch_q[i] = 1'b0;
      end
    end
    if (abort_m[s_d.ch] && s_d.phase != ST_IDLE) begin
      s_d.phase = ST_IDLE;
      s_d.bidx = 3'h0;
    end

    // Read data registered in the wait cycle, valid when waitrequest drops
    if (avs_read && !s_q.ack) begin
      case (avs_address)
        `MDCE_OFS_PTR0: s_d.rdata = {16'h0000, s_q.ptr0};
        `MDCE_OFS_PTR1: s_d.rdata = {16'h0000, s_q.ptr1};
        `MDCE_OFS_ARM: s_d.rdata = {27'h0000000, s_q.fetch_q |
                                    {s_q.chans[4].armed, s_q.chans[3].armed,
                                     s_q.chans[2].armed, s_q.chans[1].armed,
                                     s_q.chans[0].armed}};
        `MDCE_OFS_FLAG: s_d.rdata = {27'h0000000, s_q.flags};
        `MDCE_OFS_STAT: s_d.rdata = {24'h000000, 1'b0, s_q.phase, 1'b0, s_q.ch};
        `MDCE_OFS_CNT: s_d.rdata = {s_q.chans[s_q.csel].tot, 3'h0,
                                    s_q.chans[s_q.csel].cnt, s_q.csel};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign mem = mreq;
  // Processor loses only the cycles the engine takes
  assign cpu_gnt = cpu_req & ~gnt;
  assign irq_req = s_q.irq;
endmodule : mdce_engine

// ==== mdce_engine_assertions.sv ====
// Port-level assertions of the DMA channel engine
`timescale 1ns/1ps
module mdce_engine_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Memory side
  input wire mdce_pkg::mdce_mem_t mem,
  input wire logic cpu_req,
  input wire logic cpu_gnt,
  // Completion
  input wire logic [4:0] irq_req
);
  import mdce_pkg::*;
  logic [3:0] rd_run_q;
  logic [3:0] rd_run_d;
  logic [1:0] wr_run_q;
  logic [1:0] wr_run_d;
  // Length of the current run of back-to-back reads
  always_comb begin
    rd_run_d = (mem.req && !mem.we) ? rd_run_q + 4'h1 : 4'h0;
    // Writes since the last read; saturates, starts full so a write needs a read
    if (mem.req && !mem.we) begin
      wr_run_d = 2'h0;
    end else if (mem.req && wr_run_q != 2'h3) begin
      wr_run_d = wr_run_q + 2'h1;
    end else begin
      wr_run_d = wr_run_q;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_run_q <= 4'h0;
      wr_run_q <= 2'h3;
    end else begin
      rd_run_q <= rd_run_d;
      wr_run_q <= wr_run_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  gnt_excl_a: assert property (cpu_gnt |-> cpu_req && !mem.req)
    else $error("processor granted while engine accesses memory");
  gnt_free_a: assert property (cpu_req && !mem.req |-> cpu_gnt)
    else $error("idle memory withheld from processor");
  irq_pulse_a: assert property (irq_req != 5'h00 |=> irq_req == 5'h00)
    else $error("completion request longer than one cycle");
  irq_one_a: assert property ($onehot0(irq_req))
    else $error("two channels complete at once");
  rd_gap_a: assert property (mem.req && !mem.we |=> !(mem.req && mem.we))
    else $error("write directly after read");
  rd_before_wr_a: assert property (mem.req && mem.we |-> wr_run_q <= 2'h1)
    else $error("write without a read before it");
  rd_seq_a: assert property (mem.req && !mem.we && $past(mem.req && !mem.we)
    |-> mem.addr == $past(mem.addr) + 16'h0001)
    else $error("back-to-back reads not at consecutive addresses");
  wr_seq_a: assert property (mem.req && mem.we && $past(mem.req && mem.we)
    |-> mem.addr == $past(mem.addr) + 16'h0001)
    else $error("word bytes not written to consecutive addresses");
  rd_run_a: assert property (rd_run_q <= 4'h8)
    else $error("read run longer than one record");
endmodule : mdce_engine_assertions

bind mdce_engine mdce_engine_assertions u_chk (
  .clk(clk),
  .resetn(resetn),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .mem(mem),
  .cpu_req(cpu_req),
  .cpu_gnt(cpu_gnt),
  .irq_req(irq_req)
);

// ==== mdce_mem_model.sv ====
// Shared memory answering the engine's memory port
`timescale 1ns/1ps
module mdce_mem_model (
  // Clock
  input wire logic clk,
  // Engine access
  input wire mdce_pkg::mdce_mem_t mem,
  output logic [7:0] mem_rdata
);
  import mdce_pkg::*;
  logic [7:0] ram [0:65535];
  initial mem_rdata = 8'h00;
  always @(posedge clk) begin
    if (mem.req && mem.we) ram[mem.addr] <= mem.wdata;
    // Data stand one cycle only; toggling exposes late sampling
    if (mem.req && !mem.we) mem_rdata <= ram[mem.addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule : mdce_mem_model

// ==== tb_top.sv ====
// Self-checking bench of the DMA channel engine
`timescale 1ns/1ps
`include "mdce_cfg.svh"
module tb_top;
  import mdce_pkg::*;
  logic clk;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  mdce_mem_t mem;
  logic [7:0] mem_rdata;
  logic cpu_req = 1'b0;
  logic cpu_gnt;
  logic [31:0] trig_in = 32'h0;
  logic [4:0] irq_req;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int wr_cnt = 0;
  int irq_cnt [5] = '{default: 0};
  bit cpu_on = 1'b0;
  logic [1:0] cur_prio = PRIO_HIGH;

  mdce_engine dut (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem(mem),
    .mem_rdata(mem_rdata), .cpu_req(cpu_req), .cpu_gnt(cpu_gnt), .trig_in(trig_in),
    .irq_req(irq_req)
  );
  mdce_mem_model u_mem (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem.req === 1'b1 && mem.we === 1'b1) wr_cnt <= wr_cnt + 1;
    for (int i = 0; i < 5; i++) if (irq_req[i] === 1'b1) irq_cnt[i] <= irq_cnt[i] + 1;
    if (cpu_on) cpu_req <= ($urandom_range(3) == 0);
    // Record fetches lie below 0x1000 and never yield
    if (mem.req === 1'b1 && cpu_req && cur_prio == PRIO_LOW && mem.addr >= 16'h1000)
      chk(32'h1, 32'h0);
    if (cyc == 60000) begin
      chk(32'h1, 32'h0);
      report_and_stop();
    end
  end

  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= d;
    // Only the cycle ceiling ends a wait that is never answered
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] want);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, want);
  endtask : rdc

  task automatic pulse(input logic [4:0] t);
    @(posedge clk);
    trig_in <= 32'h1 << t;
    @(posedge clk);
    trig_in <= 32'h0;
  endtask : pulse

  task automatic fill;
    for (int k = 0; k < 128; k++) u_mem.ram[16'h17c0 + 16'(k)] = 8'($urandom);
    // Keeps the embedded length at one or more
    u_mem.ram[16'h1800][0] = 1'b1;
    u_mem.ram[16'h1801][0] = 1'b1;
  endtask : fill

  function automatic int units(mdce_cfg_t c, logic [15:0] first);
    int n;
    n = c.word ? int'(first[12:0]) : (c.m8 ? int'(first[14:8]) : int'(first[15:8]));
    case (c.variable_length_mode)
      VL_P1: n = n + 1;
      VL_N: n = n;
      VL_P2: n = n + 2;
      VL_P3: n = n + 3;
      default: n = c.len;
    endcase
    return (n > int'(c.len)) ? int'(c.len) : n;
  endfunction : units

  function automatic logic [15:0] step(logic [1:0] inc);
    case (inc)
      INC_1: return 16'h0001;
      INC_2: return 16'h0002;
      DEC_1: return 16'hffff;
      default: return 16'h0000;
    endcase
  endfunction : step

  task automatic run_case(input int ch, input mdce_cfg_t c, input bit sw);
    logic [15:0] ra;
    logic [15:0] sa;
    logic [15:0] da;
    logic [7:0] ex [logic [15:0]];
    int nu;
    int bpu;
    int base;
    int irq0;
    int want;
    ra = (ch == 0) ? 16'h0040 : 16'h0080 + 16'(8 * (ch - 1));
    for (int i = 0; i < 8; i++) u_mem.ram[ra + 16'(i)] = c[63 - 8 * i -: 8];
    if (ch == 0) wr(`MDCE_OFS_PTR0, 32'h0040);
    else wr(`MDCE_OFS_PTR1, 32'h0080);
    nu = units(c, {u_mem.ram[c.src], u_mem.ram[c.src + 16'h0001]});
    bpu = c.word ? 2 : 1;
    for (int k = 0; k < nu; k++) begin
      sa = c.src + 16'(k) * step(c.sinc);
      da = c.dst + 16'(k) * step(c.dinc);
      for (int b = 0; b < bpu; b++) ex[da + 16'(b)] = u_mem.ram[sa + 16'(b)];
    end
    cur_prio = c.prio;
    base = wr_cnt;
    wr(`MDCE_OFS_ARM, 32'h1 << ch);
    if (!sw) pulse(c.trig);
    repeat (12) @(posedge clk);
    chk(32'(wr_cnt - base), 32'h0);
    rdc(`MDCE_OFS_ARM, 32'h1 << ch);
    if (!sw) pulse(c.trig ^ 5'h01);
    repeat (10) @(posedge clk);
    chk(32'(wr_cnt - base), 32'h0);
    for (int p = 0; p < (c.tmode[1] ? 2 : 1); p++) begin
      base = wr_cnt;
      irq0 = irq_cnt[ch];
      foreach (ex[a]) u_mem.ram[a] = ~ex[a];
      for (int k = 0; k < (c.tmode[0] ? 1 : nu); k++) begin
        want = (c.tmode[0] ? nu : k + 1) * bpu;
        if (sw) wr(`MDCE_OFS_SWREQ, 32'h1 << ch);
        else pulse(c.trig);
        for (int g = 0; g < 400 && wr_cnt - base < want; g++) @(posedge clk);
        repeat (8) @(posedge clk);
        chk(32'(wr_cnt - base), 32'(want));
      end
      foreach (ex[a]) chk(u_mem.ram[a], ex[a]);
      rdc(`MDCE_OFS_FLAG, 32'h1 << ch);
      chk(32'(irq_cnt[ch] - irq0), 32'(c.irqm));
      wr(`MDCE_OFS_FLAG, 32'h1 << ch);
      rdc(`MDCE_OFS_ARM, c.tmode[1] ? 32'h1 << ch : 32'h0);
    end
    // Repeated modes restart the count; the others keep the final one
    want = c.tmode[1] ? int'(c.len) << 19 : (nu << 19) | (nu << 3);
    wr(`MDCE_OFS_CNT, 32'(ch));
    rdc(`MDCE_OFS_CNT, 32'(want) | 32'(ch));
    wr(`MDCE_OFS_ARM, (32'h1 << `MDCE_ABORT_POS) | (32'h1 << ch));
    rdc(`MDCE_OFS_ARM, 32'h0);
  endtask : run_case

  initial begin
    mdce_cfg_t c;
    void'($urandom(25));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdc(`MDCE_OFS_ARM, 32'h0);
    rdc(`MDCE_OFS_FLAG, 32'h0);
    wr(5'h1c, 32'hffffffff);
    rdc(5'h1c, 32'h0);
    // Top bit of the length byte ignored in seven-bit mode
    fill();
    u_mem.ram[16'h1800] = 8'h83;
    c = '{16'h1800, 16'h3800, VL_N, 13'h0014, 1'b0, TM_BLOCK, 5'h00, INC_1, INC_1,
          1'b1, 1'b1, PRIO_HIGH};
    run_case(0, c, 1'b1);
    cpu_on = 1'b1;
    for (int i = 0; i < 15; i++) begin
      fill();
      c.src = 16'h1800;
      c.dst = 16'h3800;
      c.variable_length_mode = 3'(i % 5);
      c.len = 13'($urandom_range(12, 1));
      c.word = 1'($urandom_range(1));
      c.tmode = 2'(i % 4);
      c.trig = 5'($urandom_range(29, 2));
      c.sinc = 2'(i % 4);
      c.dinc = 2'((i + 1) % 4);
      // Word units only step by zero or two bytes
      if (c.word) begin
        c.sinc[0] = 1'b0;
        c.dinc[0] = 1'b0;
      end
      c.irqm = 1'($urandom_range(1));
      c.m8 = 1'($urandom_range(1));
      c.prio = 2'($urandom_range(2));
      run_case(i % 5, c, i[0]);
    end
    report_and_stop();
  end
endmodule : tb_top
